// ==== rtl/dac_clock_datapath_config_regs.sv ====
// Clock, link and datapath configuration register group of the converter.
// Assumes a byte-wide configuration port: address, write strobe, read strobe;
// read data is registered and valid the cycle after the read strobe.
`timescale 1ns/1ps
`include "dac_cfg_map.svh"
module dac_clock_datapath_config_regs
    import dac_cfg_pkg::*;
#(
    parameter int ADDR_W = 12                   // Configuration address width
) (
    input  wire logic              core_clk_i,  // Configuration clock, 40 MHz
    input  wire logic              rst_i,       // Synchronous reset, active high
    input  wire logic [ADDR_W-1:0] cfg_addr_i,  // Register address
    input  wire logic              cfg_wr_i,    // Write strobe
    input  wire logic              cfg_rd_i,    // Read strobe
    input  wire logic [7:0]        cfg_wdata_i, // Write data
    output logic      [7:0]        cfg_rdata_o, // Read data, registered
    output logic                   cfg_rvalid_o,// Read data valid pulse
    output logic                   digital_clock_polarity_invert_o,
    output logic                   duty_correction_enable_o,
    output logic                   cross_control_enable_o,
    output logic                   dll_test_output_enable_o,
    output logic      [1:0]        dll_test_divide_o,
    output logic      [3:0]        link_lane_count_o,
    output logic      [3:0]        interpolation_ratio_select_o,
    output logic                   sinc_correction_enable_o,
    output logic                   modulation_enable_o
);
    // --------------------------------------------------------
    // Elaboration checks
    // --------------------------------------------------------
    if (ADDR_W != 12) begin : g_bad_addr
        $error("ADDR_W must be 12 to hold the register offsets");
    end

    // --------------------------------------------------------
    // Address decode
    // --------------------------------------------------------
    logic       hit_any;                        // Address maps to a register
    reg_index_t hit_idx;                        // Which register is addressed
    logic [3:0] wr_sel;                         // One-hot write strobes

    // Decode the address to one register index
    always_comb begin
        hit_any = 1'b1;
        hit_idx = REG_DIGITAL_CLOCK;
        unique case (cfg_addr_i)
            `DIGITAL_CLOCK_CONTROL_ADDR:  hit_idx = REG_DIGITAL_CLOCK;
            `DLL_CLOCK_TEST_OUTPUT_ADDR:  hit_idx = REG_DLL_TEST;
            `LANES_AND_INTERP_ADDR:       hit_idx = REG_LANES_INTERP;
            `DATAPATH_CONFIGURATION_ADDR: hit_idx = REG_DATAPATH;
            default:                      hit_any = 1'b0; // Unmapped: ignored
        endcase
        wr_sel = '0;
        if (cfg_wr_i && hit_any) begin
            wr_sel[hit_idx] = 1'b1;
        end
    end

    // --------------------------------------------------------
    // Storage
    // --------------------------------------------------------
    logic [7:0] clk_ctl;                        // Digital clock control
    logic [7:0] test_out;                       // DLL clock test output
    logic [7:0] lanes_interp;                   // Lanes and interpolation
    logic [7:0] datapath;                       // Datapath configuration

    // Polarity, duty correction, cross control; reset 0/1/1
    cfg_byte_reg #(
        .WRITE_MASK (`DIGITAL_CLOCK_CONTROL_MASK),
        .RESET_VAL  (`DIGITAL_CLOCK_CONTROL_RST)
    ) u_clk_ctl (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_sel[REG_DIGITAL_CLOCK]),
        .wr_data_i  (cfg_wdata_i),
        .value_o    (clk_ctl)
    );                                          // [R01] [R02] [R03]

    // Test output enable and divider, both reset zero
    cfg_byte_reg #(
        .WRITE_MASK (`DLL_CLOCK_TEST_OUTPUT_MASK),
        .RESET_VAL  (`DLL_CLOCK_TEST_OUTPUT_RST)
    ) u_test_out (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_sel[REG_DLL_TEST]),
        .wr_data_i  (cfg_wdata_i),
        .value_o    (test_out)
    );                                          // [R04] [R05]

    // Lane count resets to eight, ratio select to one. Software is expected
    // to write this only while the deframer sits in soft reset; the register
    // itself does not police that, since that reset lives elsewhere.
    cfg_byte_reg #(
        .WRITE_MASK (`LANES_AND_INTERP_MASK),
        .RESET_VAL  (`LANES_AND_INTERP_RST)
    ) u_lanes (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_sel[REG_LANES_INTERP]),
        .wr_data_i  (cfg_wdata_i),
        .value_o    (lanes_interp)
    );                                          // [R06] [R07] [R10]

    // Sinc correction and modulation enables; other bits belong elsewhere
    cfg_byte_reg #(
        .WRITE_MASK (`DATAPATH_CONFIGURATION_MASK),
        .RESET_VAL  (`DATAPATH_CONFIGURATION_RST)
    ) u_datapath (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .wr_en_i    (wr_sel[REG_DATAPATH]),
        .wr_data_i  (cfg_wdata_i),
        .value_o    (datapath)
    );                                          // [R08] [R09]

    // --------------------------------------------------------
    // Read path and control outputs
    // --------------------------------------------------------
    logic [7:0] rdata_ff;                       // Registered read data
    logic [7:0] nxt_rdata;
    logic       rvalid_ff;                      // Read answer pulse
    logic       nxt_rvalid;
    logic [15:0] ctl_ff;                        // Registered control outputs
    logic [15:0] nxt_ctl;

    // Read mux; unmapped addresses answer zero so software sees no junk
    always_comb begin
        nxt_rdata  = 8'h00;
        nxt_rvalid = cfg_rd_i;
        if (cfg_rd_i && hit_any) begin
            unique case (hit_idx)
                REG_DIGITAL_CLOCK: nxt_rdata = clk_ctl;
                REG_DLL_TEST:      nxt_rdata = test_out;
                REG_LANES_INTERP:  nxt_rdata = lanes_interp;
                REG_DATAPATH:      nxt_rdata = datapath;
            endcase                             // [R10]
        end
        // Outputs come from flops, so they lag the stored value by one edge
        nxt_ctl = {clk_ctl[`POLARITY_INVERT_BIT],
                   clk_ctl[`DUTY_CORRECTION_BIT],
                   clk_ctl[`CROSS_CONTROL_BIT],
                   test_out[`TEST_OUTPUT_ENABLE_BIT],
                   test_out[1:0],
                   lanes_interp[`LANE_COUNT_MSB:`LANE_COUNT_LSB],
                   lanes_interp[`RATIO_SELECT_MSB:`RATIO_SELECT_LSB],
                   datapath[`SINC_CORRECTION_BIT],
                   datapath[`MODULATION_ENABLE_BIT]};
    end

    // Register stage; reset values match the stored registers' reset
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            rdata_ff  <= 8'h00;
            rvalid_ff <= 1'b0;
            // Pol 0, duty 1, cross 1, test 0/0, lanes 8, ratio 1, sinc 0, mod 0
            ctl_ff    <= 16'h6204;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            ctl_ff    <= nxt_ctl;
        end
    end

    assign cfg_rdata_o                     = rdata_ff;
    assign cfg_rvalid_o                    = rvalid_ff;
    assign digital_clock_polarity_invert_o = ctl_ff[15]; // [R01]
    assign duty_correction_enable_o        = ctl_ff[14]; // [R02]
    assign cross_control_enable_o          = ctl_ff[13]; // [R03]
    assign dll_test_output_enable_o        = ctl_ff[12]; // [R04]
    assign dll_test_divide_o               = ctl_ff[11:10]; // [R05]
    assign link_lane_count_o               = ctl_ff[9:6]; // [R06]
    assign interpolation_ratio_select_o    = ctl_ff[5:2]; // [R10]
    assign sinc_correction_enable_o        = ctl_ff[1]; // [R08]
    assign modulation_enable_o             = ctl_ff[0]; // [R09]
endmodule : dac_clock_datapath_config_regs

// ==== rtl/dac_cfg_map.svh ====
// Offsets, field positions, reset values and masks of the clock/datapath configuration group.
// Assumes a byte-wide configuration port with a 12-bit register address.
//
// What this block does
// R01 - Bit 2 inverts the digital clock polarity
// R02 - Bit 1 enables duty-cycle correction, resets one
// R03 - Bit 0 enables cross control, resets one
// R04 - Bit 7 gates DLL clock onto test output
// R05 - Two-bit field divides DLL test clock output
// R06 - Lane count field bits 7:4, resets eight
// R07 - Software changes lanes/mode only during deframer reset; the block does not check this
// R08 - Bit 7 routes samples through sinc correction
// R09 - Bit 6 enables NCO modulation, resets zero
// R10 - Reserved bits read zero; mode resets one
`ifndef DAC_CFG_MAP_SVH
`define DAC_CFG_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define DIGITAL_CLOCK_CONTROL_ADDR   12'h09D
`define DLL_CLOCK_TEST_OUTPUT_ADDR   12'h0A0
`define LANES_AND_INTERP_ADDR        12'h110
`define DATAPATH_CONFIGURATION_ADDR  12'h111

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define POLARITY_INVERT_BIT          2
`define DUTY_CORRECTION_BIT          1
`define CROSS_CONTROL_BIT            0
`define TEST_OUTPUT_ENABLE_BIT       7
`define LANE_COUNT_MSB               7
`define LANE_COUNT_LSB               4
`define RATIO_SELECT_MSB             3
`define RATIO_SELECT_LSB             0
`define SINC_CORRECTION_BIT          7
`define MODULATION_ENABLE_BIT        6

// ----------------------------------------------------------------
// Writable-bit masks and reset values
// ----------------------------------------------------------------
`define DIGITAL_CLOCK_CONTROL_MASK   8'h07
`define DLL_CLOCK_TEST_OUTPUT_MASK   8'h83
`define LANES_AND_INTERP_MASK        8'hFF
`define DATAPATH_CONFIGURATION_MASK  8'hC0
`define DIGITAL_CLOCK_CONTROL_RST    8'h03
`define DLL_CLOCK_TEST_OUTPUT_RST    8'h00
`define LANES_AND_INTERP_RST         8'h81
`define DATAPATH_CONFIGURATION_RST   8'h00

`endif

// ==== rtl/dac_cfg_pkg.sv ====
// Types shared by the configuration group.
// Assumes dac_cfg_map.svh supplies the numbers.
package dac_cfg_pkg;
    // Index of one register in the group
    typedef enum logic [1:0] {
        REG_DIGITAL_CLOCK  = 2'b00,
        REG_DLL_TEST       = 2'b01,
        REG_LANES_INTERP   = 2'b10,
        REG_DATAPATH       = 2'b11
    } reg_index_t;
endpackage : dac_cfg_pkg

// ==== rtl/cfg_byte_reg.sv ====
// One byte-wide configuration register with a writable-bit mask.
// Assumes a single write strobe already decoded for this register.
`timescale 1ns/1ps
module cfg_byte_reg #(
    parameter logic [7:0] WRITE_MASK = 8'hFF,   // Bits that software may change
    parameter logic [7:0] RESET_VAL  = 8'h00    // Value after reset
) (
    input  wire logic       core_clk_i,         // Configuration clock
    input  wire logic       rst_i,              // Synchronous reset, active high
    input  wire logic       wr_en_i,            // Write strobe for this register
    input  wire logic [7:0] wr_data_i,          // Write data
    output logic      [7:0] value_o             // Stored value, reserved bits zero
);
    logic [7:0] value_ff;                       // Stored contents
    logic [7:0] nxt_value;                      // Next contents

    // --------------------------------------------------------
    // Next value: masked write, reserved bits forced to zero
    // --------------------------------------------------------
    always_comb begin
        nxt_value = value_ff;
        if (wr_en_i) begin
            nxt_value = wr_data_i & WRITE_MASK; // [R10]
        end
    end

    // Register stage
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            value_ff <= RESET_VAL & WRITE_MASK;
        end else begin
            value_ff <= nxt_value;
        end
    end

    assign value_o = value_ff;
endmodule : cfg_byte_reg

// ==== testbench/dac_cfg_regs_properties.sv ====
// Port-level checks for the clock, link and datapath configuration group.
// Assumes binding into the top module; one clock, synchronous high reset.
`timescale 1ns/1ps
`include "dac_cfg_map.svh"
module dac_cfg_regs_properties #(
    parameter int ADDR_W = 12                       // Address width
) (
    input wire logic              core_clk_i,
    input wire logic              rst_i,
    input wire logic [ADDR_W-1:0] cfg_addr_i,
    input wire logic              cfg_wr_i,
    input wire logic              cfg_rd_i,
    input wire logic [7:0]        cfg_wdata_i,
    input wire logic [7:0]        cfg_rdata_o,
    input wire logic              cfg_rvalid_o,
    input wire logic              digital_clock_polarity_invert_o,
    input wire logic              duty_correction_enable_o,
    input wire logic              cross_control_enable_o,
    input wire logic              dll_test_output_enable_o,
    input wire logic [1:0]        dll_test_divide_o,
    input wire logic [3:0]        link_lane_count_o,
    input wire logic [3:0]        interpolation_ratio_select_o,
    input wire logic              sinc_correction_enable_o,
    input wire logic              modulation_enable_o
);
    // --------------------------------------------------------------
    // Write hits and packed control outputs
    // --------------------------------------------------------------
    wire logic        w0 = cfg_wr_i && (cfg_addr_i == `DIGITAL_CLOCK_CONTROL_ADDR);
    wire logic        w1 = cfg_wr_i && (cfg_addr_i == `DLL_CLOCK_TEST_OUTPUT_ADDR);
    wire logic        w2 = cfg_wr_i && (cfg_addr_i == `LANES_AND_INTERP_ADDR);
    wire logic        w3 = cfg_wr_i && (cfg_addr_i == `DATAPATH_CONFIGURATION_ADDR);
    // Same order as the bench packs them
    wire logic [15:0] ctl = {digital_clock_polarity_invert_o, duty_correction_enable_o,
        cross_control_enable_o, dll_test_output_enable_o, dll_test_divide_o,
        link_lane_count_o, interpolation_ratio_select_o, sinc_correction_enable_o,
        modulation_enable_o};
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // --------------------------------------------------------------
    // Assertions: outputs settle two edges after the write edge
    // --------------------------------------------------------------
    AST_RESET_VALS: assert property ($fell(rst_i) |-> ctl == 16'h6204)
        else $error("control outputs not at reset values");
    AST_POL: assert property (w0 |-> ##2 ctl[15] == $past(cfg_wdata_i[2], 2))
        else $error("polarity output wrong");
    AST_DUTY: assert property (w0 |-> ##2 ctl[14] == $past(cfg_wdata_i[1], 2))
        else $error("duty correction output wrong");
    AST_CROSS: assert property (w0 |-> ##2 ctl[13] == $past(cfg_wdata_i[0], 2))
        else $error("cross control output wrong");
    AST_TEST_EN: assert property (w1 |-> ##2 ctl[12] == $past(cfg_wdata_i[7], 2))
        else $error("test output enable wrong");
    AST_DIV: assert property (w1 |-> ##2 ctl[11:10] == $past(cfg_wdata_i[1:0], 2))
        else $error("test divide wrong");
    AST_LANES: assert property (w2 |-> ##2 ctl[9:6] == $past(cfg_wdata_i[7:4], 2))
        else $error("lane count wrong");
    AST_RATIO: assert property (w2 |-> ##2 ctl[5:2] == $past(cfg_wdata_i[3:0], 2))
        else $error("ratio select wrong");
    AST_SINC: assert property (w3 |-> ##2 ctl[1] == $past(cfg_wdata_i[7], 2))
        else $error("sinc correction output wrong");
    AST_MOD: assert property (w3 |-> ##2 ctl[0] == $past(cfg_wdata_i[6], 2))
        else $error("modulation output wrong");
    AST_RVALID: assert property (cfg_rd_i |=> cfg_rvalid_o)
        else $error("read answer missing");
    AST_RVALID_IDLE: assert property (!cfg_rd_i |=> !cfg_rvalid_o)
        else $error("read answer without a read");
    AST_RSV_CLK: assert property (cfg_rd_i && cfg_addr_i == 12'h09D |=> cfg_rdata_o[7:3] == 5'h00)
        else $error("clock control reserved bits not zero");
    AST_IDLE_ZERO: assert property (!cfg_rvalid_o |-> cfg_rdata_o == 8'h00)
        else $error("read data not zero outside answer");
    AST_RSV_ZERO: assert property (cfg_rd_i && cfg_addr_i == 12'h111 |=> cfg_rdata_o[5:0] == 6'h00)
        else $error("reserved bits not zero");
endmodule : dac_cfg_regs_properties
bind dac_clock_datapath_config_regs dac_cfg_regs_properties #(.ADDR_W(ADDR_W)) i_props (.*);

// ==== testbench/dac_clock_datapath_config_regs_tb_top.sv ====
// Self-checking bench for the configuration group.
// Assumes the design and its map header are compiled alongside.
`timescale 1ns/1ps
`include "dac_cfg_map.svh"
module dac_clock_datapath_config_regs_tb_top;
    // --------------------------------------------------------------
    // Stimulus and observed signals
    // --------------------------------------------------------------
    logic        core_clk_i, rst_i, cfg_wr_i, cfg_rd_i, cfg_rvalid_o;
    logic [11:0] cfg_addr_i;                        // Register address
    logic [7:0]  cfg_wdata_i, cfg_rdata_o;          // Write and read data
    wire logic [15:0] ctl;                          // Packed control outputs, one driver per bit
    int          error_cnt, tests_run, cyc;         // Counters
    dac_clock_datapath_config_regs i_dut (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .cfg_addr_i(cfg_addr_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .digital_clock_polarity_invert_o(ctl[15]), .duty_correction_enable_o(ctl[14]),
        .cross_control_enable_o(ctl[13]), .dll_test_output_enable_o(ctl[12]),
        .dll_test_divide_o(ctl[11:10]), .link_lane_count_o(ctl[9:6]),
        .interpolation_ratio_select_o(ctl[5:2]), .sinc_correction_enable_o(ctl[1]),
        .modulation_enable_o(ctl[0]));
    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        cfg_addr_i  <= a;
        cfg_wdata_i <= d;
        cfg_wr_i    <= 1'b1;
        @(posedge core_clk_i);
        cfg_wr_i    <= 1'b0;
    endtask : wr
    // Read answer stands one cycle, so it is looked at just after that edge
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        cfg_addr_i <= a;
        cfg_rd_i   <= 1'b1;
        @(posedge core_clk_i);
        cfg_rd_i   <= 1'b0;
        #1;
        check({15'h0000, cfg_rvalid_o}, 16'h0001);
        check({8'h00, cfg_rdata_o}, {8'h00, e});
    endtask : rd
    // --------------------------------------------------------------
    // Scenarios
    // --------------------------------------------------------------
    task automatic t_reset;
        rd(12'h09D, 8'h03);
        rd(12'h0A0, 8'h00);
        rd(12'h110, 8'h81);
        rd(12'h111, 8'h00);
        check(ctl, 16'h6204);
    endtask : t_reset
    // Same-edge write and read returns the old value
    task automatic t_same_edge;
        @(posedge core_clk_i);
        {cfg_addr_i, cfg_wdata_i, cfg_wr_i, cfg_rd_i} <= {12'h09D, 8'h00, 2'b11};
        @(posedge core_clk_i);
        {cfg_wr_i, cfg_rd_i} <= 2'b00;
        #1;
        check({8'h00, cfg_rdata_o}, 16'h0003);
        rd(12'h09D, 8'h00);
    endtask : t_same_edge
    // Every writable field, reserved bits dropped; all four registers written and read back
    task automatic t_fields(input logic [7:0] v);
        wr(12'h09D, v);
        wr(12'h0A0, v);
        wr(12'h110, v);
        wr(12'h111, v);
        rd(12'h09D, v & 8'h07);
        rd(12'h0A0, v & 8'h83);
        rd(12'h110, v);
        rd(12'h111, v & 8'hC0);
        check(ctl, {v[2:0], v[7], v[1:0], v, v[7:6]});
    endtask : t_fields
    // Back-to-back writes, then a read one edge after a write, then an unmapped place
    task automatic t_b2b_unmapped;
        @(posedge core_clk_i);
        {cfg_addr_i, cfg_wdata_i, cfg_wr_i} <= {12'h111, 8'h80, 1'b1};
        @(posedge core_clk_i);
        {cfg_addr_i, cfg_wdata_i} <= {12'h110, 8'hA5};
        @(posedge core_clk_i);
        {cfg_wr_i, cfg_rd_i} <= 2'b01;
        @(posedge core_clk_i);
        cfg_rd_i <= 1'b0;
        #1;
        check({8'h00, cfg_rdata_o}, 16'h00A5);
        rd(12'h111, 8'h80);
        wr(12'h0A1, 8'hFF);
        rd(12'h0A1, 8'h00);
        rd(12'h0A0, 8'h00);
    endtask : t_b2b_unmapped
    // Mid-run reset held two edges: outputs show reset values once it is released
    task automatic t_mid_reset;
        wr(12'h09D, 8'h04);
        @(posedge core_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        #1;
        check(ctl, 16'h6204);
        rd(12'h09D, 8'h03);
    endtask : t_mid_reset
    // --------------------------------------------------------------
    // Clock, timeout, verdict and main sequence
    // --------------------------------------------------------------
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end
    // Cut a hang short well past the expected run length
    always @(posedge core_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            results();
        end
    end
    initial begin
        {rst_i, cfg_wr_i, cfg_rd_i, cfg_addr_i, cfg_wdata_i} = {3'b100, 20'h00000};
        {error_cnt, tests_run, cyc} = '0;
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_same_edge();
        t_fields(8'hFF);
        t_fields(8'h5A);
        t_fields(8'h00);
        t_b2b_unmapped();
        t_mid_reset();
        results();
    end
endmodule : dac_clock_datapath_config_regs_tb_top
